// File: hw/ucd_pkg.sv
// constants for the channel command decoder: register map, fields, codes
// assumes a 40 MHz pclk and APB access with one 32-bit word per register
package ucd_pkg;

  // register indices; byte address is four times the index
  localparam int ADDR_W = 6;
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_COMMAND = 4'h2;
  localparam logic [3:0] IDX_ISR = 4'h5;
  localparam logic [3:0] IDX_CONTROL = 4'hC;
  localparam logic [3:0] IDX_STATE = 4'hD;

  // command byte fields
  localparam int CMD_RX_EN = 0;
  localparam int CMD_RX_DIS = 1;
  localparam int CMD_TX_EN = 2;
  localparam int CMD_TX_DIS = 3;
  localparam int CMD_MISC_LSB = 4;

  // control register fields and reset value
  localparam int CTRL_MULTIDROP = 0;
  localparam int CTRL_WAKEUP = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // interrupt status field
  localparam int ISR_BRK_CHG = 2;

  // mode register pointer values
  localparam logic [1:0] MRPTR_MR0 = 2'h0;
  localparam logic [1:0] MRPTR_MR1 = 2'h1;

  // timing
  localparam longint PCLK_FREQ_HZ = 40000000;
  localparam longint XTAL_FREQ_HZ = 3686400;
  // both crystal edges count, so the edge interval is half a period
  localparam int XTAL_EDGE_CYC = int'(PCLK_FREQ_HZ / (2 * XTAL_FREQ_HZ));
  localparam logic [1:0] MISC_GAP_EDGES = 2'h3;
  localparam longint BAUD_DEFAULT = 9600;
  localparam int BIT_CYC_DEFAULT = int'(PCLK_FREQ_HZ / BAUD_DEFAULT);

  typedef enum logic [3:0] {
    MISC_NONE = 4'h0,
    MISC_PTR_MR1 = 4'h1,
    MISC_RX_RST = 4'h2,
    MISC_TX_RST = 4'h3,
    MISC_ERR_CLR = 4'h4,
    MISC_BRKCHG_CLR = 4'h5,
    MISC_BRK_START = 4'h6,
    MISC_BRK_STOP = 4'h7,
    MISC_RTS_ON = 4'h8,
    MISC_RTS_OFF = 4'h9,
    MISC_PTR_MR0 = 4'hB
  } ucd_misc_type;

  typedef enum logic [4:0] {
    BRK_IDLE = 5'h01,
    BRK_WAIT = 5'h02,
    BRK_ON = 5'h04,
    BRK_RELEASE = 5'h08,
    BRK_MARK = 5'h10
  } ucd_brk_type;

  function automatic logic ucd_mapped(input logic [3:0] idx);
    ucd_mapped = (idx == IDX_STATUS) || (idx == IDX_COMMAND) || (idx == IDX_ISR) ||
      (idx == IDX_CONTROL) || (idx == IDX_STATE);
  endfunction

endpackage

// File: hw/ucd_tick_div.sv
// free-running divider giving a one-cycle enable every DIV clocks
// assumes a single clock domain with asynchronous active-low reset
`timescale 1ns/10ps
module ucd_tick_div
  import ucd_pkg::*;
#(
  parameter int DIV = 5
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // enable out
  output logic tick
);

  localparam int CW = $clog2(DIV + 1);

  logic [CW-1:0] cnt_r;

  if (DIV < 1)
  begin : g_bad_div
    $error("divider must be at least one");
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= '0;
    else if (cnt_r == CW'(DIV - 1))
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + CW'(1);
  end

  assign tick = (cnt_r == CW'(DIV - 1));

endmodule

// File: hw/ucd_apb_slave.sv
// APB slave front end: word decode, write strobe, read return, error answer
// assumes zero-wait access; read data comes from the caller's registers
`timescale 1ns/10ps
module ucd_apb_slave
  import ucd_pkg::*;
(
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // register side
  output logic wr_stb,
  output logic [3:0] reg_idx,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);

  logic access;
  logic hit;

  assign access = psel && penable;
  assign reg_idx = paddr[5:2];
  // misaligned byte addresses are treated as unmapped
  assign hit = (paddr[1:0] == 2'h0) && ucd_mapped(reg_idx);
  assign pready = 1'b1;
  assign pslverr = access && !hit;
  assign wr_stb = access && pwrite && hit;
  assign wr_data = pwdata[7:0];
  assign prdata = (access && !pwrite && hit) ? {24'h000000, rd_data} : 32'h00000000;

endmodule

// File: hw/ucd_cmd_decoder.sv
// channel command decoder: low-nibble enables, upper-nibble command codes
// assumes transmitter/receiver cores elsewhere consume the pulses and levels
//
// Behaviour
// - enable bits of a written byte act at once, its code at a later crystal edge; host avoids conflicting ones.
// - bit 3 stops transmitter, clears ready and empty flags, queued chars finish.
// - bit 2 enables transmitter; idle transmitter then shows ready and empty.
// - bit 1 stops receiver at once, drops partial char, leaves status alone.
// - special multi-drop mode keeps receiver running while disabled.
// - bit 0 enables receiver and starts start-bit hunt unless wake-up mode.
// - code 0 does nothing; code 1 points mode pointer at first mode register.
// - code 2 resets receiver: disabled and receive FIFO flushed.
// - code 3 resets transmitter as a hardware reset does.
// - code 4 clears break, framing, parity and overrun status bits.
// - code 5 clears the break-change bit of interrupt status.
// - code 6 forces serial output low once transmitter has emptied.
// - start-break is ignored while the transmitter is disabled.
// - code 7 restores mark within two bit times, holds one bit time.
// - code 8 drives the send request output low.
// - upper nibble is a command code apart from the four enable bits.
// - code 9 drives the send request output high.
// - code 11 points mode pointer at the zeroth mode register.
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
module ucd_cmd_decoder
  import ucd_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYC_DEFAULT
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmitter core
  input wire logic tx_idle_in,
  input wire logic tx_room_in,
  input wire logic tx_serial_in,
  output logic tx_run,
  output logic tx_reset_out,
  output logic tx_hold_off,
  output logic serial_out_a,
  // receiver core
  input wire logic rx_ready_in,
  input wire logic rx_full_in,
  input wire logic rx_break_event,
  input wire logic rx_framing_event,
  input wire logic rx_parity_event,
  input wire logic rx_overrun_event,
  input wire logic rx_break_change_event,
  output logic rx_run,
  output logic rx_abort_out,
  output logic rx_hunt_out,
  output logic rx_flush_out,
  // channel control
  output logic [1:0] mode_ptr,
  output logic send_request_out_n
);

  if (BIT_CYC < 2)
  begin : g_bad_bit
    $error("bit time must span at least two clocks");
  end

  logic wr_stb;
  logic [3:0] reg_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic xtal_tick;
  logic bit_tick;
  logic cmd_wr;
  logic [3:0] wr_code;
  logic misc_pend_r;
  logic [3:0] misc_code_r;
  logic [1:0] gap_r;
  logic misc_go;
  logic tx_en_r;
  logic rx_en_r;
  logic tx_ready_flag_r;
  logic tx_empty_flag_r;
  logic [3:0] err_r;
  logic brk_chg_r;
  logic [7:0] ctrl_r;
  logic rts_n_r;
  logic [1:0] mode_ptr_r;
  ucd_brk_type brk_r;
  logic [7:0] channel_a_status_reg;
  logic [7:0] interrupt_status_reg;

  function automatic logic go_is(input logic go, input logic [3:0] code, input ucd_misc_type c);
    go_is = go && (code == c);
  endfunction

  ucd_apb_slave u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .wr_stb(wr_stb),
    .reg_idx(reg_idx),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  ucd_tick_div #(.DIV(XTAL_EDGE_CYC)) u_xtal (
    .pclk(pclk),
    .presetn(presetn),
    .tick(xtal_tick)
  );

  ucd_tick_div #(.DIV(BIT_CYC)) u_bit (
    .pclk(pclk),
    .presetn(presetn),
    .tick(bit_tick)
  );

  assign cmd_wr = wr_stb && (reg_idx == IDX_COMMAND);
  assign wr_code = wr_data[7:CMD_MISC_LSB];

  // upper-nibble commands wait for a crystal edge and the edge spacing
  assign misc_go = misc_pend_r && xtal_tick && (gap_r >= MISC_GAP_EDGES);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      misc_pend_r <= 1'b0;
      misc_code_r <= MISC_NONE;
    end
    else if (cmd_wr && (wr_code != MISC_NONE))
    begin
      misc_pend_r <= 1'b1;
      misc_code_r <= wr_code;
    end
    else if (misc_go)
      misc_pend_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gap_r <= MISC_GAP_EDGES;
    else if (misc_go)
      gap_r <= 2'h0;
    else if (xtal_tick && (gap_r != MISC_GAP_EDGES))
      gap_r <= gap_r + 2'h1;
  end

  // transmitter enable; a disable bit beats an enable bit in the same byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_en_r <= 1'b0;
    else if (go_is(misc_go, misc_code_r, MISC_TX_RST))
      tx_en_r <= 1'b0;
    else if (cmd_wr && wr_data[CMD_TX_DIS])
      tx_en_r <= 1'b0;
    else if (cmd_wr && wr_data[CMD_TX_EN])
      tx_en_r <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_ready_flag_r <= 1'b0;
      tx_empty_flag_r <= 1'b0;
    end
    else if (go_is(misc_go, misc_code_r, MISC_TX_RST) || (cmd_wr && wr_data[CMD_TX_DIS]))
    begin
      tx_ready_flag_r <= 1'b0;
      tx_empty_flag_r <= 1'b0;
    end
    else
    begin
      tx_ready_flag_r <= tx_en_r && tx_room_in;
      tx_empty_flag_r <= tx_en_r && tx_idle_in;
    end
  end

  // a disabled transmitter keeps running until its queue drains
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_run <= 1'b0;
      tx_reset_out <= 1'b0;
    end
    else
    begin
      tx_run <= !go_is(misc_go, misc_code_r, MISC_TX_RST) && (tx_en_r || !tx_idle_in);
      tx_reset_out <= go_is(misc_go, misc_code_r, MISC_TX_RST);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_en_r <= 1'b0;
    else if (go_is(misc_go, misc_code_r, MISC_RX_RST))
      rx_en_r <= 1'b0;
    else if (cmd_wr && wr_data[CMD_RX_DIS])
      rx_en_r <= 1'b0;
    else if (cmd_wr && wr_data[CMD_RX_EN])
      rx_en_r <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_abort_out <= 1'b0;
      rx_hunt_out <= 1'b0;
      rx_flush_out <= 1'b0;
      rx_run <= 1'b0;
    end
    else
    begin
      rx_abort_out <= cmd_wr && wr_data[CMD_RX_DIS] && !ctrl_r[CTRL_MULTIDROP];
      rx_hunt_out <= cmd_wr && wr_data[CMD_RX_EN] && !wr_data[CMD_RX_DIS] &&
        !ctrl_r[CTRL_WAKEUP];
      rx_flush_out <= go_is(misc_go, misc_code_r, MISC_RX_RST);
      rx_run <= rx_en_r || ctrl_r[CTRL_MULTIDROP];
    end
  end

  // sticky receive errors; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_r <= 4'h0;
    else if (go_is(misc_go, misc_code_r, MISC_ERR_CLR) || go_is(misc_go, misc_code_r, MISC_RX_RST))
      err_r <= {rx_break_event, rx_framing_event, rx_parity_event, rx_overrun_event};
    else
      err_r <= err_r | {rx_break_event, rx_framing_event, rx_parity_event, rx_overrun_event};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      brk_chg_r <= 1'b0;
    else if (go_is(misc_go, misc_code_r, MISC_BRKCHG_CLR))
      brk_chg_r <= rx_break_change_event;
    else
      brk_chg_r <= brk_chg_r | rx_break_change_event;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= CTRL_RESET;
    else if (wr_stb && (reg_idx == IDX_CONTROL))
      ctrl_r <= {6'h00, wr_data[CTRL_WAKEUP], wr_data[CTRL_MULTIDROP]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rts_n_r <= 1'b1;
    else if (go_is(misc_go, misc_code_r, MISC_RTS_ON))
      rts_n_r <= 1'b0;
    else if (go_is(misc_go, misc_code_r, MISC_RTS_OFF))
      rts_n_r <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_ptr_r <= MRPTR_MR1;
    else if (go_is(misc_go, misc_code_r, MISC_PTR_MR1))
      mode_ptr_r <= MRPTR_MR1;
    else if (go_is(misc_go, misc_code_r, MISC_PTR_MR0))
      mode_ptr_r <= MRPTR_MR0;
  end

  // break sequencing; starts and stops on bit-time boundaries, except that code 3 idles it at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      brk_r <= BRK_IDLE;
    else if (go_is(misc_go, misc_code_r, MISC_TX_RST))
      brk_r <= BRK_IDLE;
    else
    begin
      case (brk_r)
        BRK_IDLE:
          if (go_is(misc_go, misc_code_r, MISC_BRK_START) && tx_en_r)
            brk_r <= BRK_WAIT;
        BRK_WAIT:
          if (go_is(misc_go, misc_code_r, MISC_BRK_STOP))
            brk_r <= BRK_IDLE;
          else if (tx_idle_in && bit_tick)
            brk_r <= BRK_ON;
        BRK_ON:
          if (go_is(misc_go, misc_code_r, MISC_BRK_STOP))
            brk_r <= BRK_RELEASE;
        BRK_RELEASE:
          if (bit_tick)
            brk_r <= BRK_MARK;
        BRK_MARK:
          if (bit_tick)
            brk_r <= BRK_IDLE;
        default:
          brk_r <= BRK_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      serial_out_a <= 1'b1;
    else
      serial_out_a <= (brk_r == BRK_ON || brk_r == BRK_RELEASE) ? 1'b0 : tx_serial_in;
  end

  // transmitter may not start a character during break or the mark gap
  assign tx_hold_off = (brk_r == BRK_ON) || (brk_r == BRK_RELEASE) || (brk_r == BRK_MARK);
  assign send_request_out_n = rts_n_r;
  assign mode_ptr = mode_ptr_r;

  assign channel_a_status_reg = {err_r, tx_empty_flag_r, tx_ready_flag_r, rx_full_in, rx_ready_in};
  assign interrupt_status_reg = {5'h00, brk_chg_r, 2'h0};

  always_comb
  begin
    case (reg_idx)
      IDX_STATUS: rd_data = channel_a_status_reg;
      IDX_ISR: rd_data = interrupt_status_reg;
      IDX_CONTROL: rd_data = ctrl_r;
      IDX_STATE: rd_data = {mode_ptr_r, (brk_r != BRK_IDLE), misc_pend_r, rts_n_r, 1'b0,
        tx_en_r, rx_en_r};
      default: rd_data = 8'h00;
    endcase
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_brk_release;
    (brk_r == BRK_RELEASE) && bit_tick;
  endsequence

  sequence s_brk_mark;
    (brk_r == BRK_MARK) [*2];
  endsequence

  a_tx_disable_flags: assert property (cmd_wr && wr_data[CMD_TX_DIS] |=>
    !tx_ready_flag_r && !tx_empty_flag_r && !tx_en_r)
    else $error("transmitter disable left flags set");
  a_tx_enable_idle: assert property (cmd_wr && wr_data[CMD_TX_EN] &&
    !wr_data[CMD_TX_DIS] && !misc_go ##1 (tx_idle_in && !cmd_wr && !misc_go) |=> tx_empty_flag_r)
    else $error("idle enabled transmitter not empty");
  a_rx_disable_drop: assert property (cmd_wr && wr_data[CMD_RX_DIS] &&
    !ctrl_r[CTRL_MULTIDROP] && !misc_go |=> rx_abort_out && !rx_en_r && (err_r == $past(err_r |
    {rx_break_event, rx_framing_event, rx_parity_event, rx_overrun_event})))
    else $error("receiver disable did not drop character");
  a_rx_multidrop_run: assert property (ctrl_r[CTRL_MULTIDROP] |=> rx_run)
    else $error("receiver stopped in multi-drop mode");
  a_rx_enable_hunt: assert property (cmd_wr && wr_data[CMD_RX_EN] &&
    !wr_data[CMD_RX_DIS] && !ctrl_r[CTRL_WAKEUP] |=> rx_hunt_out)
    else $error("receiver enable without hunt");
  a_misc_spacing: assert property (misc_go |=> !misc_go [*2])
    else $error("command codes executed too close");
  a_ptr_first: assert property (go_is(misc_go, misc_code_r, MISC_PTR_MR1) |=>
    mode_ptr == MRPTR_MR1)
    else $error("mode pointer not at first register");
  a_ptr_zero: assert property (go_is(misc_go, misc_code_r, MISC_PTR_MR0) |=>
    mode_ptr == MRPTR_MR0)
    else $error("mode pointer not at zeroth register");
  a_rx_reset_flush: assert property (go_is(misc_go, misc_code_r, MISC_RX_RST) |=>
    rx_flush_out && !rx_en_r)
    else $error("receiver reset incomplete");
  a_tx_reset_all: assert property (go_is(misc_go, misc_code_r, MISC_TX_RST) |=>
    tx_reset_out && !tx_en_r && (brk_r == BRK_IDLE) && !tx_run)
    else $error("transmitter reset incomplete");
  a_err_clear: assert property (go_is(misc_go, misc_code_r, MISC_ERR_CLR) &&
    !rx_break_event && !rx_framing_event && !rx_parity_event && !rx_overrun_event |=>
    err_r == 4'h0)
    else $error("error status not cleared");
  a_brkchg_clear: assert property (go_is(misc_go, misc_code_r, MISC_BRKCHG_CLR) &&
    !rx_break_change_event |=> !interrupt_status_reg[ISR_BRK_CHG])
    else $error("break change bit not cleared");
  a_break_low: assert property ((brk_r == BRK_ON) |=> !serial_out_a)
    else $error("serial output high during break");
  a_break_ignored: assert property (go_is(misc_go, misc_code_r, MISC_BRK_START) &&
    !tx_en_r && (brk_r == BRK_IDLE) |=> brk_r == BRK_IDLE)
    else $error("break accepted with transmitter disabled");
  a_stop_mark: assert property (s_brk_release |=> s_brk_mark ##0 tx_hold_off)
    else $error("mark gap after break too short");
  a_rts_low: assert property (go_is(misc_go, misc_code_r, MISC_RTS_ON) |=>
    !send_request_out_n)
    else $error("send request not asserted");
  a_rts_high: assert property (go_is(misc_go, misc_code_r, MISC_RTS_OFF) |=>
    send_request_out_n)
    else $error("send request not negated");
  a_zero_bits_hold: assert property (cmd_wr && (wr_data[3:0] == 4'h0) && !misc_go |=>
    $stable(tx_en_r) && $stable(rx_en_r))
    else $error("zero enable bits changed state");

endmodule

// File: sim/ucd_host_model.sv
// host processor model: APB master for the channel registers
// assumes pclk from the bench and a slave that raises pready in time
`timescale 1ns/10ps
module ucd_host_model
  import ucd_pkg::*;
(
  // clock
  input wire logic pclk,
  // apb
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic hung = 1'b0;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end

  // request held until the edge that samples pready high
  task automatic xfer(input logic we, input logic [3:0] idx, input logic [7:0] d,
    output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= we;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    hung = hung | (n >= 64);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // gap of 20 clocks covers three crystal edges and the execution latency
  task automatic command(input logic [7:0] c);
    logic [31:0] rd;
    logic err;
    xfer(1'b1, IDX_COMMAND, c, rd, err);
    repeat (20) @(posedge pclk);
  endtask
endmodule

// File: sim/tb.sv
// self-checking bench for the channel command decoder
// assumes the host model as APB master; bench drives the core inputs
`timescale 1ns/10ps
module tb;
  import ucd_pkg::*;
  localparam int BIT = 8;
  logic pclk = 1'b0;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, st;
  logic tx_idle_in, tx_room_in, tx_serial_in, rx_ready_in, rx_full_in, rx_chg;
  logic [3:0] rx_err;
  logic tx_run, tx_reset_out, tx_hold_off, serial_out_a, rx_run;
  logic rx_abort_out, rx_hunt_out, rx_flush_out, send_request_out_n;
  logic [1:0] mode_ptr;
  logic [31:0] lfsr = 32'h1F6725FD;
  logic ten = 1'b0;
  logic ren = 1'b0;
  logic [7:0] c;
  int err_count = 0;
  int samples_checked = 0;
  int n_abort = 0, n_hunt = 0, n_flush = 0, n_txrst = 0;
  int e_abort = 0, e_hunt = 0, n;

  always #12.5 pclk = ~pclk;

  always @(posedge pclk)
  begin
    n_abort <= n_abort + int'(rx_abort_out);
    n_hunt <= n_hunt + int'(rx_hunt_out);
    n_flush <= n_flush + int'(rx_flush_out);
    n_txrst <= n_txrst + int'(tx_reset_out);
  end

  ucd_cmd_decoder #(.BIT_CYC(BIT)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_idle_in(tx_idle_in), .tx_room_in(tx_room_in),
    .tx_serial_in(tx_serial_in), .tx_run(tx_run), .tx_reset_out(tx_reset_out),
    .tx_hold_off(tx_hold_off), .serial_out_a(serial_out_a), .rx_ready_in(rx_ready_in),
    .rx_full_in(rx_full_in), .rx_break_event(rx_err[3]), .rx_framing_event(rx_err[2]),
    .rx_parity_event(rx_err[1]), .rx_overrun_event(rx_err[0]),
    .rx_break_change_event(rx_chg), .rx_run(rx_run), .rx_abort_out(rx_abort_out),
    .rx_hunt_out(rx_hunt_out), .rx_flush_out(rx_flush_out), .mode_ptr(mode_ptr),
    .send_request_out_n(send_request_out_n));

  ucd_host_model HOST (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] exp_status(input logic [3:0] e, input logic t,
    input logic i, input logic r, input logic f, input logic y);
    return {24'h0, e, t & i, t & r, f, y};
  endfunction

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rreg(input logic [3:0] idx);
    HOST.xfer(1'b0, idx, 8'h00, rd, er);
  endtask

  task automatic close_out;
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    close_out();
  end

  initial
  begin
    presetn <= 1'b0;
    {tx_idle_in, tx_room_in, tx_serial_in} <= 3'h7;
    {rx_ready_in, rx_full_in, rx_chg, rx_err} <= 7'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("rts_rst", 32'h1, send_request_out_n);
    check("ptr_rst", MRPTR_MR1, mode_ptr);
    rreg(4'h0);
    check("unmapped", 32'h1, er);
    rreg(IDX_CONTROL);
    check("ctrl_rst", CTRL_RESET, rd);
    // random enable and disable bits, never both of one pair
    repeat (10)
    begin
      lfsr = nxt(lfsr);
      {tx_serial_in, tx_idle_in, tx_room_in, rx_ready_in, rx_full_in} <= lfsr[8:4];
      c = {4'h0, (lfsr[3:2] == 2'h3) ? 2'h0 : lfsr[3:2], (lfsr[1:0] == 2'h3) ? 2'h0 : lfsr[1:0]};
      ten = c[3] ? 1'b0 : (c[2] ? 1'b1 : ten);
      ren = c[1] ? 1'b0 : (c[0] ? 1'b1 : ren);
      e_abort += int'(c[1]);
      e_hunt += int'(c[0]);
      HOST.command(c);
      rreg(IDX_STATE);
      check("en_bits", {30'h0, ten, ren}, {30'h0, rd[1:0]});
      rreg(IDX_STATUS);
      check("status", exp_status(4'h0, ten, tx_idle_in, tx_room_in, rx_full_in, rx_ready_in), rd);
      check("tx_run", {31'h0, ten | ~tx_idle_in}, tx_run);
      check("rx_run", {31'h0, ren}, rx_run);
      check("serial", {31'h0, tx_serial_in}, serial_out_a);
      check("abort", e_abort, n_abort);
      check("hunt", e_hunt, n_hunt);
    end
    tx_serial_in <= 1'b1;
    HOST.xfer(1'b1, IDX_CONTROL, 8'h01, rd, er);
    HOST.command(8'h02);
    check("md_run", 32'h1, rx_run);
    check("md_abort", e_abort, n_abort);
    HOST.xfer(1'b1, IDX_CONTROL, 8'h02, rd, er);
    HOST.command(8'h01);
    check("wk_hunt", e_hunt, n_hunt);
    HOST.xfer(1'b1, IDX_CONTROL, 8'h00, rd, er);
    HOST.command(8'hB0);
    check("ptr0", MRPTR_MR0, mode_ptr);
    rreg(IDX_STATE);
    st = rd;
    HOST.command(8'h00);
    rreg(IDX_STATE);
    check("nop", st, rd);
    HOST.command(8'h10);
    check("ptr1", MRPTR_MR1, mode_ptr);
    HOST.command(8'h85);
    check("rts_on", 32'h0, send_request_out_n);
    rreg(IDX_STATE);
    check("en_both", 32'h3, rd[1:0]);
    HOST.command(8'h90);
    check("rts_off", 32'h1, send_request_out_n);
    rx_err <= 4'hF;
    rx_chg <= 1'b1;
    @(posedge pclk);
    rx_err <= 4'h0;
    rx_chg <= 1'b0;
    rreg(IDX_STATUS);
    check("err_set", 32'hF, rd[7:4]);
    HOST.command(8'h40);
    rreg(IDX_STATUS);
    check("err_clr", 32'h0, rd[7:4]);
    rreg(IDX_ISR);
    check("chg_set", 32'h1, rd[ISR_BRK_CHG]);
    HOST.command(8'h50);
    rreg(IDX_ISR);
    check("chg_clr", 32'h0, rd[ISR_BRK_CHG]);
    HOST.command(8'h20);
    rreg(IDX_STATE);
    check("rx_rst_en", 32'h0, rd[0]);
    check("flush", 32'h1, n_flush);
    HOST.command(8'h30);
    check("tx_rst", 32'h1, n_txrst);
    // break with transmitter off must be dropped
    HOST.command(8'h08);
    HOST.command(8'h60);
    rreg(IDX_STATE);
    check("brk_ign", 32'h0, rd[5]);
    check("brk_ign_line", 32'h1, serial_out_a);
    tx_idle_in <= 1'b0;
    HOST.command(8'h64);
    check("brk_busy", 32'h1, serial_out_a);
    tx_idle_in <= 1'b1;
    for (n = 0; n < 2 * BIT + 4 && serial_out_a !== 1'b0; n++) @(posedge pclk);
    check("brk_on", 32'h0, serial_out_a);
    HOST.xfer(1'b1, IDX_COMMAND, 8'h70, rd, er);
    for (n = 0; n < 16 + 2 * BIT + 4 && serial_out_a !== 1'b1; n++) @(posedge pclk);
    check("brk_off", 32'h1, serial_out_a);
    for (n = 0; n < 4 * BIT && tx_hold_off === 1'b1; n++) @(posedge pclk);
    check("mark_hold", 32'h1, n >= BIT - 2);
    check("hold_end", 32'h0, tx_hold_off);
    check("host_hang", 32'h0, HOST.hung);
    close_out();
  end
endmodule
